// ===== core/sdf_filter.sv
// Purpose: Sinc3 decimation filter top for a one-bit modulator stream
// Assumes: ref_clk is the master clock; modulator bit is synchronous
// Notes: Output word is the filtered density scaled to OUT_W bits
`timescale 1ns/1ps
// Operation
// - Modulator strobe fires once per 128 master clocks for any gain.
// - Input sample rate is clock/64 times 1, 2, 4 or 8 by gain.
// - Reference sample strobe is clock/64, independent of gain.
// - Polarity bit does not change output coding; both map density directly.
// - Filter is three cascaded N-sample moving sums.
// - Output word rate equals the first notch; notches at multiples.
// - Rate select only changes decimation ratio, not response shape.
// - Exact integer moving sums give deep nulls at the notches.
// - Datapath keeps one headroom bit, so density up to twice full scale is held before saturating.
// - After an unsynchronised step, three outputs are flagged unsettled.
// - After synchronisation the third output is the first settled one.
// - Rate codes give 50 to 500 Hz at 2.4576 MHz master clock.
module sdf_filter
#(
    parameter int OUT_W = sdf_pkg::OUT_W,
    parameter logic [8:0] DEC_RATIO_0 = sdf_pkg::DEC_RATIO_0,
    parameter logic [8:0] DEC_RATIO_1 = sdf_pkg::DEC_RATIO_1,
    parameter logic [8:0] DEC_RATIO_2 = sdf_pkg::DEC_RATIO_2,
    parameter logic [8:0] DEC_RATIO_3 = sdf_pkg::DEC_RATIO_3
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic modulator_bit,
    input wire logic filter_sync,
    input wire logic notch_rate_sel_lo,
    input wire logic notch_rate_sel_hi,
    input wire logic unipolar,
    input wire logic [2:0] gain_sel,
    input wire logic step_detect,
    output logic mod_strobe,
    output logic in_sample_strobe,
    output logic ref_sample_strobe,
    output logic [OUT_W-1:0] data_out,
    output logic data_valid,
    output logic data_settled,
    output logic overrange
);
    typedef enum logic [1:0]
    {
        SDF_HOLD = 2'b00,
        SDF_SETTLE = 2'b01,
        SDF_RUN = 2'b10
    } sdf_state_t;

    // =========================================================
    // Rate strobes
    // =========================================================
    sdf_rate_gen u_rate
    (
        .ref_clk(ref_clk),
        .reset(reset),
        .gain_sel(gain_sel),
        .mod_strobe(mod_strobe),
        .in_sample_strobe(in_sample_strobe),
        .ref_sample_strobe(ref_sample_strobe)
    );

    // =========================================================
    // Rate selection
    // =========================================================
    logic [1:0] rate_code;
    logic [8:0] dec_ratio;
    assign rate_code = {notch_rate_sel_hi, notch_rate_sel_lo};
    // Only N moves with the code; the cascade itself is fixed
    assign dec_ratio = (rate_code == 2'h0) ? DEC_RATIO_0 :
                       (rate_code == 2'h1) ? DEC_RATIO_1 :
                       (rate_code == 2'h2) ? DEC_RATIO_2 :
                       DEC_RATIO_3;

    // =========================================================
    // Sinc3 core
    // =========================================================
    logic [31:0] cic_sum;
    logic cic_valid;

    sdf_sinc3_core
    #(
        .ACC_W(sdf_pkg::ACC_W),
        .DEC_W(sdf_pkg::DEC_W)
    )
    u_core
    (
        .ref_clk(ref_clk),
        .reset(reset),
        .clear(filter_sync),
        .sample_valid(mod_strobe),
        .sample_bit(modulator_bit),
        .dec_ratio(dec_ratio),
        .sum_out(cic_sum),
        .sum_valid(cic_valid)
    );

    // =========================================================
    // Scaling: sum / N^3 is the ones density in [0,1]
    // =========================================================
    // N^3 full scale; a 64-bit product keeps all bits before the divide
    logic [31:0] full_scale;
    logic [63:0] scaled;
    logic [63:0] quot;
    logic [OUT_W:0] density;
    assign full_scale = 32'(dec_ratio) * 32'(dec_ratio) * 32'(dec_ratio);
    assign scaled = {{(32-OUT_W){1'b0}}, cic_sum, {OUT_W{1'b0}}};
    // A divider per output is costly but keeps any N exact
    assign quot = scaled / {32'h00000000, full_scale};
    // Extra bit keeps above-full-scale density visible
    assign density = (quot[63:OUT_W+1] != '0) ?
                     {(OUT_W+1){1'b1}} : quot[OUT_W:0];

    // =========================================================
    // Output coding
    // =========================================================
    logic [OUT_W-1:0] code_word;
    logic code_over;
    // Both polarities: density maps directly to the code word, no midscale offset
    assign code_over = density[OUT_W];
    assign code_word = code_over ? {OUT_W{1'b1}} :
                       unipolar ? density[OUT_W-1:0] :
                       density[OUT_W-1:0];

    // =========================================================
    // Settling control
    // =========================================================
    sdf_state_t state_reg;
    sdf_state_t state_next;
    logic [2:0] settle_reg;
    logic [2:0] settle_next;
    logic settle_done;

    assign settle_done = cic_valid && (settle_reg <= 3'h1);

    always_comb
    begin
        state_next = state_reg;
        settle_next = settle_reg;
        case (state_reg)
            SDF_HOLD:
            begin
                if (!filter_sync)
                begin
                    state_next = SDF_SETTLE;
                    settle_next = 3'(sdf_pkg::SETTLE_SYNC);
                end
            end
            SDF_SETTLE:
            begin
                if (cic_valid)
                begin
                    settle_next = settle_reg - 3'h1;
                    if (settle_done)
                        state_next = SDF_RUN;
                end
            end
            SDF_RUN:
            begin
                if (step_detect)
                begin
                    state_next = SDF_SETTLE;
                    settle_next = 3'(sdf_pkg::SETTLE_STEP);
                end
            end
            default:
            begin
                state_next = SDF_HOLD;
                settle_next = 3'h0;
            end
        endcase
        if (filter_sync)
        begin
            state_next = SDF_HOLD;
            settle_next = 3'h0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_reg <= SDF_SETTLE;
            settle_reg <= 3'(sdf_pkg::SETTLE_SYNC);
        end
        else
        begin
            state_reg <= state_next;
            settle_reg <= settle_next;
        end
    end

    // =========================================================
    // Output registers
    // =========================================================
    logic [OUT_W-1:0] data_reg;
    logic valid_reg;
    logic settled_reg;
    logic over_reg;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            data_reg <= '0;
            valid_reg <= 1'b0;
            settled_reg <= 1'b0;
            over_reg <= 1'b0;
        end
        else
        begin
            valid_reg <= cic_valid && !filter_sync;
            if (cic_valid && !filter_sync)
            begin
                data_reg <= code_word;
                over_reg <= code_over;
                settled_reg <= (state_reg == SDF_RUN) || settle_done;
            end
        end
    end

    assign data_out = data_reg;
    assign data_valid = valid_reg;
    assign data_settled = settled_reg;
    assign overrange = over_reg;
endmodule

// ===== core/sdf_pkg.sv
// Purpose: Constants shared by the sinc3 decimation filter design
// Assumes: Master clock drives ref_clk; one-bit modulator stream
// Notes: Rates are expressed as master clock divide ratios
package sdf_pkg;
    // =========================================================
    // Clock division
    // =========================================================
    localparam int MOD_DIV = 128;
    localparam int REF_SAMPLE_DIV = 64;
    localparam int IN_SAMPLE_DIV = 64;
    localparam int DIV_CNT_W = 7;
    // =========================================================
    // Gain codes
    // =========================================================
    localparam int GAIN_W = 3;
    localparam logic [2:0] GAIN_1 = 3'h0;
    localparam logic [2:0] GAIN_2 = 3'h1;
    localparam logic [2:0] GAIN_4 = 3'h2;
    // =========================================================
    // Decimation ratios for the four notch rate codes
    // 19200 / N gives 50, 60, 250, 500 Hz at 2.4576 MHz
    // =========================================================
    localparam int DEC_W = 9;
    localparam logic [8:0] DEC_RATIO_0 = 9'h180;
    localparam logic [8:0] DEC_RATIO_1 = 9'h140;
    localparam logic [8:0] DEC_RATIO_2 = 9'h04D;
    localparam logic [8:0] DEC_RATIO_3 = 9'h026;
    // =========================================================
    // Settling
    // =========================================================
    localparam int SETTLE_SYNC = 3;
    localparam int SETTLE_STEP = 4;
    localparam int SETTLE_W = 3;
    // =========================================================
    // Datapath
    // =========================================================
    localparam int ACC_W = 32;
    localparam int OUT_W = 16;
    localparam int HEADROOM_BITS = 1;
endpackage

// ===== core/sdf_rate_gen.sv
// Purpose: Modulator, input and reference sampling strobes
// Assumes: Strobes are one ref_clk cycle wide
// Notes: Modulator rate is independent of gain
`timescale 1ns/1ps
module sdf_rate_gen
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [2:0] gain_sel,
    output logic mod_strobe,
    output logic in_sample_strobe,
    output logic ref_sample_strobe
);
    // =========================================================
    // Free running divider
    // =========================================================
    logic [6:0] div_reg;
    logic [6:0] div_next;
    logic [5:0] in_mask;

    assign div_next = div_reg + 7'h01;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            div_reg <= 7'h00;
        else
            div_reg <= div_next;
    end

    // Gain 1,2,4 sample 1,2,4 times per 64 clocks; above that 8 times
    assign in_mask = (gain_sel == sdf_pkg::GAIN_1) ? 6'h3F :
                     (gain_sel == sdf_pkg::GAIN_2) ? 6'h1F :
                     (gain_sel == sdf_pkg::GAIN_4) ? 6'h0F : 6'h07;

    assign mod_strobe = (div_reg == 7'h7F);
    assign in_sample_strobe = ((div_reg[5:0] & in_mask) == in_mask);
    assign ref_sample_strobe = (div_reg[5:0] == 6'h3F);
endmodule

// ===== core/sdf_sinc3_core.sv
// Purpose: Cascaded integrator comb sinc3 decimator
// Assumes: Input sample arrives on mod_strobe
// Notes: Wraparound arithmetic is exact for CIC at this width
`timescale 1ns/1ps
module sdf_sinc3_core
#(
    parameter int ACC_W = 32,
    parameter int DEC_W = 9
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic sample_valid,
    input wire logic sample_bit,
    input wire logic [DEC_W-1:0] dec_ratio,
    output logic [ACC_W-1:0] sum_out,
    output logic sum_valid
);
    // =========================================================
    // Integrators and decimation counter
    // =========================================================
    logic [ACC_W-1:0] int_reg [3];
    logic [ACC_W-1:0] comb_reg [3];
    logic [ACC_W-1:0] comb_val [4];
    logic [DEC_W-1:0] dec_cnt_reg;
    logic [ACC_W-1:0] sum_reg;
    logic valid_reg;
    logic dec_tick;

    assign dec_tick = sample_valid && (dec_cnt_reg == dec_ratio - 1'b1);
    // Take the last integrator as it updates: one less sample of lag lets
    // the third word after a sync cover only fresh samples
    assign comb_val[0] = int_reg[2] + int_reg[1];

    genvar s;
    generate
        for (s = 0; s < 3; s++)
        begin : g_stage
            logic [ACC_W-1:0] int_in;
            if (s == 0)
            begin : g_first
                assign int_in = {{(ACC_W-1){1'b0}}, sample_bit};
            end
            else
            begin : g_rest
                assign int_in = int_reg[s-1];
            end
            assign comb_val[s+1] = comb_val[s] - comb_reg[s];
            always_ff @(posedge ref_clk)
            begin
                if (reset || clear)
                begin
                    int_reg[s] <= '0;
                    comb_reg[s] <= '0;
                end
                else
                begin
                    if (sample_valid)
                        int_reg[s] <= int_reg[s] + int_in;
                    if (dec_tick)
                        comb_reg[s] <= comb_val[s];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk)
    begin
        if (reset || clear)
        begin
            dec_cnt_reg <= '0;
            sum_reg <= '0;
            valid_reg <= 1'b0;
        end
        else
        begin
            valid_reg <= dec_tick;
            if (dec_tick)
                sum_reg <= comb_val[3];
            if (dec_tick)
                dec_cnt_reg <= '0;
            else if (sample_valid)
                dec_cnt_reg <= dec_cnt_reg + 1'b1;
        end
    end

    assign sum_out = sum_reg;
    assign sum_valid = valid_reg;
endmodule

// ===== tb/sdf_filter_props.sv
// Purpose: Port timing checks for the sinc3 filter
// Assumes: Bound to sdf_filter
// Notes: Gap counters measure strobe spacing
`timescale 1ns/1ps
module sdf_filter_props
#(
    parameter int OUT_W = 16
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic filter_sync,
    input wire logic [2:0] gain_sel,
    input wire logic mod_strobe,
    input wire logic in_sample_strobe,
    input wire logic ref_sample_strobe,
    input wire logic [OUT_W-1:0] data_out,
    input wire logic data_valid,
    input wire logic overrange
);
    // ====================================
    // Strobe spacing
    // ====================================
    logic [6:0] mgap_reg, rgap_reg, igap_reg, iexp;
    logic [2:0] gain_reg, seen_reg;
    logic gain_same;
    assign gain_same = gain_reg == gain_sel;
    assign iexp = gain_sel == 3'h0 ? 7'h3F : gain_sel == 3'h1 ? 7'h1F :
        gain_sel == 3'h2 ? 7'h0F : 7'h07;
    always_ff @(posedge ref_clk)
    begin
        mgap_reg <= mod_strobe ? 7'h00 : mgap_reg + 7'h01;
        rgap_reg <= ref_sample_strobe ? 7'h00 : rgap_reg + 7'h01;
        igap_reg <= in_sample_strobe ? 7'h00 : igap_reg + 7'h01;
        gain_reg <= gain_sel;
        // A gain change restarts the input gap check
        seen_reg <= reset ? 3'h0 : {gain_same &&
            (seen_reg[2] || in_sample_strobe),
            seen_reg[1] || ref_sample_strobe, seen_reg[0] || mod_strobe};
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_mod_period: assert property (
        mod_strobe && seen_reg[0] |-> mgap_reg == 7'h7F)
        else $error("modulator strobe spacing wrong");
    a_ref_period: assert property (
        ref_sample_strobe && seen_reg[1] |-> rgap_reg == 7'h3F)
        else $error("reference strobe spacing wrong");
    a_in_period: assert property (
        in_sample_strobe && seen_reg[2] && gain_same |-> igap_reg == iexp)
        else $error("input strobe spacing wrong");
    a_valid_pulse: assert property (
        data_valid |=> !data_valid)
        else $error("data valid longer than one cycle");
    a_valid_cause: assert property (
        data_valid |-> $past(mod_strobe, 2))
        else $error("word not two cycles after a sample");
    a_sync_quiet: assert property (
        filter_sync [*3] |-> !data_valid)
        else $error("word produced while sync held");
    a_over_sat: assert property (
        overrange |-> data_out == {OUT_W{1'b1}})
        else $error("overrange word not saturated");
    a_reset_clear: assert property (
        $fell(reset) |-> !data_valid && data_out == '0)
        else $error("outputs not cleared by reset");
endmodule

// ===== tb/sdf_mod_model.sv
// Purpose: First order modulator model feeding the filter
// Assumes: Bit advances on each mod_strobe
// Notes: Accumulator phase survives density changes
`timescale 1ns/1ps
module sdf_mod_model
(
    input wire logic ref_clk,
    input wire logic mod_strobe,
    input wire logic [15:0] density,
    input wire logic all_ones,
    output logic modulator_bit
);
    // ====================================
    // Carry of a phase accumulator
    // ====================================
    logic [15:0] acc_reg = 16'h0000;
    logic [16:0] acc_next;
    assign acc_next = {1'b0, acc_reg} + {1'b0, density};
    initial modulator_bit = 1'b0;
    always @(posedge ref_clk)
        if (mod_strobe)
        begin
            acc_reg <= #1 acc_next[15:0];
            modulator_bit <= #1 acc_next[16] | all_ones;
        end
endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the sinc3 filter
// Assumes: Small decimation ratios keep the run short
// Notes: Densities of period four give exact words
`timescale 1ns/1ps
module testbench;
    // ====================================
    // Clock, stimulus and design
    // ====================================
    logic ref_clk = 1'b0, reset = 1'b1, filter_sync = 1'b0;
    logic step_detect = 1'b0, unipolar = 1'b0, all_ones = 1'b0;
    logic [1:0] code = 2'h0;
    logic [2:0] gain_sel = 3'h0;
    logic [15:0] density = 16'h0000, data_out;
    logic modulator_bit, mod_strobe, data_valid, data_settled, overrange;
    logic [31:0] seed = 32'h7FFE;
    int n_errors = 0, total_checks = 0, gap;
    initial forever #5 ref_clk = ~ref_clk;
    sdf_mod_model partner(.ref_clk(ref_clk), .mod_strobe(mod_strobe),
        .density(density), .all_ones(all_ones),
        .modulator_bit(modulator_bit));
    sdf_filter #(.DEC_RATIO_0(9'h004), .DEC_RATIO_1(9'h008),
        .DEC_RATIO_2(9'h00C), .DEC_RATIO_3(9'h010)) dut(.ref_clk(ref_clk),
        .reset(reset), .modulator_bit(modulator_bit),
        .filter_sync(filter_sync), .notch_rate_sel_lo(code[0]),
        .notch_rate_sel_hi(code[1]), .unipolar(unipolar),
        .gain_sel(gain_sel), .step_detect(step_detect),
        .mod_strobe(mod_strobe), .in_sample_strobe(), .ref_sample_strobe(),
        .data_out(data_out), .data_valid(data_valid),
        .data_settled(data_settled), .overrange(overrange));
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Coding map is the same for both polarities
    function automatic logic [15:0] exp_word(input logic o,
        input logic [15:0] d);
        return o ? 16'hFFFF : d;
    endfunction
    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] want);
        total_checks++;
        if (seen !== want)
        begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, want, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic next_word;
        gap = 0;
        do
        begin
            tick;
            gap++;
        end
        while (data_valid !== 1'b1 && gap < 4000);
        check("word arrival", 32'(gap < 4000), 32'h1);
    endtask
    task automatic check_word(input logic o, input logic [15:0] d);
        check("data_out", data_out, exp_word(o, d));
        check("overrange", overrange, o);
        check("settled", data_settled, 1'b1);
    endtask
    task automatic sync_test(input logic [1:0] c, input logic o,
        input logic [15:0] d);
        code = c;
        all_ones = o;
        density = d;
        filter_sync = 1'b1;
        // Hold sync past two samples so no old bit enters the window
        repeat (300) tick;
        filter_sync = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            next_word;
            if (k < 2)
                check("early settled", data_settled, 1'b0);
            else
                check_word(o, d);
        end
        check("word spacing", gap, 512 * (c + 1));
        $display("sync test code %0d density %0h done", c, d);
    endtask
    task automatic step_test(input logic [15:0] d);
        next_word;
        all_ones = 1'b0;
        density = d;
        step_detect = 1'b1;
        tick;
        step_detect = 1'b0;
        for (int k = 0; k < 5; k++)
        begin
            next_word;
            if (k < 3)
                check("step settled", data_settled, 1'b0);
        end
        check_word(1'b0, d);
        $display("step test done");
    endtask
    // ====================================
    // Main sequence and watchdog
    // ====================================
    initial
    begin
        repeat (4) tick;
        reset = 1'b0;
        for (int t = 0; t < 6; t++)
        begin
            seed = xs(seed);
            gain_sel = seed[2:0];
            unipolar = seed[3];
            sync_test(t < 4 ? t[1:0] : seed[5:4], 1'b0,
                {seed[7:6], 14'h0000});
        end
        sync_test(2'h3, 1'b0, 16'h0000);
        sync_test(2'h1, 1'b1, 16'h0000);
        step_test(16'h4000);
        complete_run;
    end
    initial
    begin
        #800000;
        n_errors++;
        $display("[FAIL] watchdog expected finish seen hang");
        complete_run;
    end
endmodule
bind sdf_filter sdf_filter_props #(.OUT_W(OUT_W)) props(.ref_clk(ref_clk),
    .reset(reset), .filter_sync(filter_sync), .gain_sel(gain_sel),
    .mod_strobe(mod_strobe), .in_sample_strobe(in_sample_strobe),
    .ref_sample_strobe(ref_sample_strobe), .data_out(data_out),
    .data_valid(data_valid), .overrange(overrange));
